// ==== sim/pin_source.sv ====
/*
  Far-side model: count clock and gate pin sources.
  Assumes requests come on core_clk_i edges.
*/
`timescale 1ns/1ps
`default_nettype none
module pin_source (
  input  wire logic core_clk_i,
  input  wire logic sys_rst_i,
  input  wire logic pulse_i,
  input  wire logic gate_i,
  output logic      count_clk_o,
  output logic      gate_pin_o
);
  logic [3:0] hold_q;
  ////////////////////////////////////////////////////////////
  // Count clock stands low between pulses
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
      hold_q <= 4'h0;
    else if (pulse_i)
      hold_q <= 4'h8;
    else if (hold_q != 4'h0)
      hold_q <= hold_q - 4'h1;
  end
  assign count_clk_o = (hold_q != 4'h0);
  assign gate_pin_o  = gate_i;
endmodule
`default_nettype wire

// ==== sim/test_timer_gate_ctrl.sv ====
/*
  Self-checking bench for the gated timer.
  Assumes the pin_source model and the timer package.
*/
`timescale 1ns/1ps
`default_nettype none
module test_timer_gate_ctrl;
  import timer_gate_pkg::*;
  logic        core_clk_i = 1'b0;
  logic        sys_rst_i  = 1'b1;
  logic        pulse_q = 1'b0;
  logic        gate_q  = 1'b0;
  logic        sleep_q = 1'b0;
  logic        cev_q   = 1'b0;
  logic        rclr_q  = 1'b0;
  logic        gclr_q  = 1'b0;
  logic        wdo_q   = 1'b0;
  logic        cclk;
  logic        gpin;
  gate_cfg_t   gcfg = '0;
  irq_cfg_t    icfg = '0;
  cnt_wr_t     wr   = '0;
  ccp_mode_t   mode = CCP_OFF;
  logic [15:0] cmp  = 16'h0000;
  logic [15:0] cnt, capv, vaddr;
  logic        ce, arm, gst, gflag, rflag, rirq, girq, wake, vec;
  wdog_ctl_t   wdc;
  int          bad_count = 0;
  int          n_checks  = 0;
  int          wake_n    = 0;
  int          vec_n     = 0;
  ////////////////////////////////////////////////////////////
  // Clock, far side and design
  always #2 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i)
  begin
    if (wake === 1'b1) wake_n++;
    if (vec === 1'b1) vec_n++;
  end
  pin_source ps (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .pulse_i(pulse_q), .gate_i(gate_q),
    .count_clk_o(cclk), .gate_pin_o(gpin));
  timer_gate_ctrl uut (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .count_clk_i(cclk),
    .gate_pin_i(gpin), .wd_osc_i(wdo_q), .gate_cfg_i(gcfg), .irq_cfg_i(icfg), .cnt_wr_i(wr),
    .sleep_i(sleep_q), .ccp_mode_i(mode), .capture_event_i(cev_q), .compare_val_i(cmp),
    .rollover_flag_clr_i(rclr_q), .gate_event_flag_clr_i(gclr_q), .counter_o(cnt),
    .capture_val_o(capv), .compare_event_o(ce), .gate_arm_bit_o(arm), .gate_level_status_o(gst),
    .gate_event_flag_o(gflag), .rollover_flag_o(rflag), .rollover_irq_o(rirq),
    .gate_event_irq_o(girq), .wake_o(wake), .vector_o(vec), .vector_addr_o(vaddr), .wdog_ctl_o(wdc));
  ////////////////////////////////////////////////////////////
  // Tasks
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    #1;
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk16({15'h0000, got}, {15'h0000, exp});
  endtask
  task automatic wr_cnt(input logic [15:0] v);
    @(posedge core_clk_i) wr <= '{1'b1, 1'b0, v[7:0]};
    @(posedge core_clk_i) wr <= '{1'b0, 1'b1, v[15:8]};
    @(posedge core_clk_i) wr <= '0;
    cyc(1);
  endtask
  task automatic count();
    @(posedge core_clk_i) pulse_q <= 1'b1;
    @(posedge core_clk_i) pulse_q <= 1'b0;
    cyc(20);
  endtask
  task automatic arm_it();
    @(posedge core_clk_i) gcfg.gate_arm_set <= 1'b1;
    @(posedge core_clk_i) gcfg.gate_arm_set <= 1'b0;
    cyc(2);
  endtask
  task automatic pin(input logic v);
    @(posedge core_clk_i) gate_q <= v;
    cyc(8);
  endtask
  task automatic gclr();
    @(posedge core_clk_i) gclr_q <= 1'b1;
    @(posedge core_clk_i) gclr_q <= 1'b0;
    cyc(2);
  endtask
  task automatic done(input string name);
    $display("test %s finished", name);
  endtask
  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    cyc(16);
    sys_rst_i <= 1'b0;
    cyc(6);
    chk16(cnt, CNT_ZERO);
    chk1(rflag, 1'b0);
    chk16(vaddr, ISR_VECTOR);
    for (int i = 0; i < 8; i++)
    begin
      @(posedge core_clk_i) icfg.watchdog_enable <= i[2];
      gcfg.gate_enable <= i[1];
      gcfg.gate_source_select <= i[0] ? GSRC_WATCHDOG : 2'h0;
      cyc(1);
      chk16(16'(wdc), 16'({i[2] | (i[1] & i[0]), i[2], i[2]}));
    end
    @(posedge core_clk_i) gcfg <= '0;
    icfg <= '0;
    done("watchdog");
    @(posedge core_clk_i) icfg.timer_run <= 1'b1;
    wr_cnt(16'hff12);
    chk16(cnt, 16'hff12);
    count();
    chk16(cnt, 16'hff13);
    wr_cnt(16'hffff);
    count();
    chk16(cnt, CNT_ZERO);
    chk1(rflag, 1'b1);
    @(posedge core_clk_i) icfg <= '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
    cyc(2);
    chk1(rirq, 1'b1);
    @(posedge core_clk_i) icfg.timer_run <= 1'b0;
    cyc(2);
    chk1(rirq, 1'b0);
    @(posedge core_clk_i) rclr_q <= 1'b1;
    icfg.timer_run <= 1'b1;
    @(posedge core_clk_i) rclr_q <= 1'b0;
    cyc(2);
    chk1(rflag, 1'b0);
    done("rollover");
    @(posedge core_clk_i) sleep_q <= 1'b1;
    wr_cnt(16'h0100);
    count();
    chk16(cnt, 16'h0100);
    @(posedge core_clk_i) icfg.sync_bypass <= 1'b1;
    wr_cnt(16'hffff);
    count();
    chk16(cnt, CNT_ZERO);
    chk16(16'(wake_n), 16'h0001);
    chk16(16'(vec_n), 16'h0001);
    @(posedge core_clk_i) sleep_q <= 1'b0;
    icfg.sync_bypass <= 1'b0;
    rclr_q <= 1'b1;
    @(posedge core_clk_i) rclr_q <= 1'b0;
    done("sleep");
    @(posedge core_clk_i) mode <= CCP_SPECIAL;
    cmp <= 16'h0011;
    wr_cnt(16'h0010);
    count();
    chk16(cnt, CNT_ZERO);
    chk1(rflag, 1'b0);
    @(posedge core_clk_i) mode <= CCP_OFF;
    cmp <= 16'h0311;
    wr_cnt(16'h0311);
    @(posedge core_clk_i) mode <= CCP_SPECIAL;
    wr <= '{1'b1, 1'b0, 8'h22};
    @(posedge core_clk_i) wr <= '0;
    cyc(2);
    chk16(cnt, 16'h0322);
    @(posedge core_clk_i) mode <= CCP_COMPARE;
    cmp <= 16'h0322;
    cyc(3);
    chk1(ce, 1'b1);
    chk16(cnt, 16'h0322);
    @(posedge core_clk_i) mode <= CCP_CAPTURE;
    wr_cnt(16'h1234);
    @(posedge core_clk_i) cev_q <= 1'b1;
    @(posedge core_clk_i) cev_q <= 1'b0;
    cyc(3);
    chk16(capv, 16'h1234);
    @(posedge core_clk_i) mode <= CCP_OFF;
    done("ccp");
    @(posedge core_clk_i) gcfg.gate_polarity <= 1'b1;
    cyc(8);
    gclr();
    chk1(gflag, 1'b0);
    pin(1'b1);
    chk1(gst, 1'b1);
    pin(1'b0);
    chk1(gst, 1'b0);
    chk1(gflag, 1'b1);
    chk1(girq, 1'b1);
    cyc(10);
    chk1(gflag, 1'b1);
    gclr();
    chk1(gflag, 1'b0);
    done("gate event");
    // toggle enabled alone, polarity already settled
    @(posedge core_clk_i) gcfg.gate_toggle_enable <= 1'b1;
    pin(1'b1);
    chk1(gst, 1'b1);
    pin(1'b0);
    chk1(gst, 1'b1);
    pin(1'b1);
    chk1(gst, 1'b0);
    chk1(gflag, 1'b1);
    pin(1'b0);
    pin(1'b1);
    chk1(gst, 1'b1);
    @(posedge core_clk_i) gcfg.gate_toggle_enable <= 1'b0;
    pin(1'b0);
    @(posedge core_clk_i) gcfg.gate_toggle_enable <= 1'b1;
    cyc(2);
    chk1(gst, 1'b0);
    @(posedge core_clk_i) gcfg.gate_toggle_enable <= 1'b0;
    gcfg.gate_source_select <= GSRC_WATCHDOG;
    wdo_q <= 1'b1;
    cyc(8);
    chk1(gst, 1'b1);
    @(posedge core_clk_i) wdo_q <= 1'b0;
    gcfg.gate_source_select <= 2'h0;
    cyc(8);
    gclr();
    done("toggle");
    @(posedge core_clk_i) gcfg <= '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 2'h0};
    cyc(2);
    chk1(arm, 1'b0);
    arm_it();
    chk1(arm, 1'b1);
    wr_cnt(16'h0040);
    pin(1'b1);
    count();
    count();
    chk16(cnt, 16'h0041);
    pin(1'b0);
    chk1(arm, 1'b0);
    wr_cnt(16'h0050);
    pin(1'b1);
    count();
    chk16(cnt, 16'h0050);
    arm_it();
    chk1(arm, 1'b1);
    @(posedge core_clk_i) gcfg.gate_single_pulse_enable <= 1'b0;
    cyc(2);
    chk1(arm, 1'b0);
    done("single pulse");
    report_and_stop();
  end
endmodule
`default_nettype wire

// ==== verilog/edge_sync.sv ====
/*
  Three-stage synchroniser with edge detection for one external input.
  Assumes the input is asynchronous to core_clk_i; a change is accepted
  when stages two and three agree.
*/
`timescale 1ns/1ps
`default_nettype none
module edge_sync (
  input  wire logic core_clk_i,
  input  wire logic sys_rst_i,
  input  wire logic async_i,
  output logic      level_o,
  output logic      rise_o,
  output logic      fall_o
);
  import timer_gate_pkg::*;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } sync_state_t;

  sync_state_t q, d;

  always_comb
  begin
    d     = q;
    d.s1  = async_i;
    d.s2  = q.s1;
    d.s3  = q.s2;
    if (q.s2 == q.s3)
    begin
      d.lvl = q.s3;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign level_o = q.lvl;
  assign rise_o  = d.lvl & ~q.lvl;
  assign fall_o  = ~d.lvl & q.lvl;
endmodule
`default_nettype wire

// ==== verilog/timer_gate_ctrl.sv ====
/*
  Gate, rollover, sleep and capture/compare time base of a 16-bit timer.
  Assumes count and gate inputs are asynchronous pins; capture event and
  capture/compare mode come from logic on core_clk_i.
*/
// Functional notes
// - Watchdog oscillator shared as gate source
// - Toggle flop flips on each polarity-adjusted gate rising edge
// - Toggle flop held clear when disabled
// - Armed single pulse opens on next edge, counts from the one after
// - Trailing edge disarms; later events ignored
// - Clearing single-pulse enable clears arm
// - Toggle plus single pulse counts one cycle
// - Gate level status always readable
// - Gate level fall sets event flag
// - Gate event flag works without gate enable
// - Counter wraps at maximum, sets rollover flag
// - Rollover irq needs four enables
// - Sleep counting only in asynchronous mode
// - Sleep overflow wakes, vectors if global
// - Capture copies counter on event
// - Compare match raises event
// - Special trigger clears counter, no rollover
// - Counter write beats special trigger
`timescale 1ns/1ps
`default_nettype none
module timer_gate_ctrl (
  input  wire logic                    core_clk_i,
  input  wire logic                    sys_rst_i,
  input  wire logic                    count_clk_i,
  input  wire logic                    gate_pin_i,
  input  wire logic                    wd_osc_i,
  input  wire timer_gate_pkg::gate_cfg_t gate_cfg_i,
  input  wire timer_gate_pkg::irq_cfg_t  irq_cfg_i,
  input  wire timer_gate_pkg::cnt_wr_t   cnt_wr_i,
  input  wire logic                    sleep_i,
  input  wire timer_gate_pkg::ccp_mode_t ccp_mode_i,
  input  wire logic                    capture_event_i,
  input  wire logic [15:0]             compare_val_i,
  input  wire logic                    rollover_flag_clr_i,
  input  wire logic                    gate_event_flag_clr_i,
  output logic [15:0]                  counter_o,
  output logic [15:0]                  capture_val_o,
  output logic                         compare_event_o,
  output logic                         gate_arm_bit_o,
  output logic                         gate_level_status_o,
  output logic                         gate_event_flag_o,
  output logic                         rollover_flag_o,
  output logic                         rollover_irq_o,
  output logic                         gate_event_irq_o,
  output logic                         wake_o,
  output logic                         vector_o,
  output logic [15:0]                  vector_addr_o,
  output var timer_gate_pkg::wdog_ctl_t wdog_ctl_o
);
  import timer_gate_pkg::*;

  typedef struct packed {
    logic [15:0] cnt;
    logic [15:0] cap;
    logic        cmp_ev;
    logic        toggle;
    logic        arm;
    logic        sp_open;
    logic        gval;
    logic        gev_flag;
    logic        ro_flag;
    logic        wake;
    logic        vec;
    logic        spm_prev;
  } tmr_state_t;

  tmr_state_t q, d;

  logic inc_lvl, inc_edge;
  logic gpin_lvl;
  logic gsrc_raw, gsrc_pol, gate_ctl, gate_allow;
  logic cnt_enable, cnt_tick, wrap, special_hit, wr_any;
  logic [15:0] cnt_inc;
  logic gate_mux, gsrc_rise, gsrc_fall, gsrc_pol_rise;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers

  edge_sync u_inc_sync (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .async_i    (count_clk_i),
    .level_o    (inc_lvl),
    .rise_o     (inc_edge),
    .fall_o     ()
  );

  edge_sync u_gate_sync (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .async_i    (gate_mux),
    .level_o    (gpin_lvl),
    .rise_o     (gsrc_rise),
    .fall_o     (gsrc_fall)
  );

  assign gate_mux = (gate_cfg_i.gate_source_select == GSRC_WATCHDOG) ? wd_osc_i : gate_pin_i;

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog oscillator sharing

  always_comb
  begin
    wdog_ctl_o.wd_osc_run     = irq_cfg_i.watchdog_enable
                              | (gate_cfg_i.gate_enable & (gate_cfg_i.gate_source_select == GSRC_WATCHDOG));
    wdog_ctl_o.wd_reset_allow = irq_cfg_i.watchdog_enable;
    wdog_ctl_o.wd_wake_allow  = irq_cfg_i.watchdog_enable;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Gate path and counting

  always_comb
  begin
    gsrc_raw   = gpin_lvl;
    gsrc_pol   = gsrc_raw ^ ~gate_cfg_i.gate_polarity;
    gsrc_pol_rise = gate_cfg_i.gate_polarity ? gsrc_rise : gsrc_fall;
    gate_ctl   = gate_cfg_i.gate_toggle_enable ? q.toggle : gsrc_pol;
    gate_allow = gate_cfg_i.gate_single_pulse_enable ? (q.sp_open & gate_ctl) : gate_ctl;
    cnt_enable = irq_cfg_i.timer_run & (~gate_cfg_i.gate_enable | gate_allow)
               & (~sleep_i | irq_cfg_i.sync_bypass);
    cnt_tick   = cnt_enable & inc_edge;
    cnt_inc    = q.cnt + 16'h0001;
    wrap       = cnt_tick & (q.cnt == CNT_MAX);
    special_hit = (ccp_mode_i == CCP_SPECIAL) & (q.cnt == compare_val_i);
    wr_any     = cnt_wr_i.wr_low | cnt_wr_i.wr_high;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    d          = q;
    d.spm_prev = gate_cfg_i.gate_single_pulse_enable;
    d.gval     = gate_ctl;

    if (gsrc_pol_rise)
    begin
      d.toggle = ~q.toggle;
    end
    if (!gate_cfg_i.gate_toggle_enable)
    begin
      d.toggle = 1'b0;
    end

    // Arm opens on next incrementing edge
    if (gate_cfg_i.gate_arm_set & gate_cfg_i.gate_single_pulse_enable)
    begin
      d.arm = 1'b1;
    end
    if (q.arm & ~q.sp_open & inc_edge & gate_ctl)
    begin
      d.sp_open = 1'b1;
    end
    // Trailing edge ends pulse and disarms
    if (q.sp_open & q.gval & ~gate_ctl)
    begin
      d.sp_open = 1'b0;
      d.arm     = 1'b0;
    end
    if (!gate_cfg_i.gate_single_pulse_enable)
    begin
      d.arm     = 1'b0;
      d.sp_open = 1'b0;
    end

    if (gate_event_flag_clr_i)
    begin
      d.gev_flag = 1'b0;
    end
    if (q.gval & ~gate_ctl)
    begin
      d.gev_flag = 1'b1;
    end

    if (rollover_flag_clr_i)
    begin
      d.ro_flag = 1'b0;
    end

    if (special_hit)
    begin
      d.cnt = CNT_ZERO;
    end
    else if (cnt_tick)
    begin
      d.cnt = cnt_inc;
      if (wrap)
      begin
        d.ro_flag = 1'b1;
      end
    end
    if (cnt_wr_i.wr_low)
    begin
      d.cnt[7:0] = cnt_wr_i.wdata;
    end
    if (cnt_wr_i.wr_high)
    begin
      d.cnt[15:8] = cnt_wr_i.wdata;
    end
    if (wr_any & special_hit)
    begin
      if (!cnt_wr_i.wr_low)
      begin
        d.cnt[7:0] = q.cnt[7:0];
      end
      if (!cnt_wr_i.wr_high)
      begin
        d.cnt[15:8] = q.cnt[15:8];
      end
    end

    if ((ccp_mode_i == CCP_CAPTURE) & capture_event_i)
    begin
      d.cap = q.cnt;
    end
    d.cmp_ev = ((ccp_mode_i == CCP_COMPARE) | (ccp_mode_i == CCP_SPECIAL)) & (q.cnt == compare_val_i);

    d.wake = sleep_i & wrap & irq_cfg_i.timer_run & irq_cfg_i.rollover_irq_enable
           & irq_cfg_i.peripheral_irq_enable;
    d.vec  = d.wake & irq_cfg_i.global_irq_enable;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign counter_o           = q.cnt;
  assign capture_val_o       = q.cap;
  assign compare_event_o     = q.cmp_ev;
  assign gate_arm_bit_o      = q.arm;
  assign gate_level_status_o = q.gval;
  assign gate_event_flag_o   = q.gev_flag;
  assign rollover_flag_o     = q.ro_flag;
  assign rollover_irq_o      = q.ro_flag & irq_cfg_i.timer_run & irq_cfg_i.rollover_irq_enable
                             & irq_cfg_i.peripheral_irq_enable & irq_cfg_i.global_irq_enable;
  assign gate_event_irq_o    = q.gev_flag & irq_cfg_i.gate_event_irq_enable
                             & irq_cfg_i.peripheral_irq_enable & irq_cfg_i.global_irq_enable;
  assign wake_o              = q.wake;
  assign vector_o            = q.vec;
  assign vector_addr_o       = ISR_VECTOR;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  a_toggle_held: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    !gate_cfg_i.gate_toggle_enable |=> !q.toggle)
    else $error("toggle flop not held clear");

  a_spm_clears_arm: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    !gate_cfg_i.gate_single_pulse_enable |=> !gate_arm_bit_o)
    else $error("arm survived single-pulse disable");

  a_gate_flag_set: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    $fell(gate_level_status_o) |-> gate_event_flag_o)
    else $error("gate event flag missed falling level");

  a_flag_sticky: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    gate_event_flag_o && !gate_event_flag_clr_i |=> gate_event_flag_o)
    else $error("gate event flag dropped without clear");

  a_wrap_flag: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    wrap && !special_hit && !wr_any |=> counter_o == CNT_ZERO && rollover_flag_o)
    else $error("wrap did not zero counter and set flag");

  a_special_clear: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    special_hit && !wr_any && !rollover_flag_o && !wrap |=> counter_o == CNT_ZERO && !rollover_flag_o)
    else $error("special trigger misbehaved");

  a_write_wins: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    special_hit && cnt_wr_i.wr_low |=> counter_o[7:0] == $past(cnt_wr_i.wdata))
    else $error("special trigger beat counter write");

  a_capture_copy: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    ccp_mode_i == CCP_CAPTURE && capture_event_i |=> capture_val_o == $past(counter_o))
    else $error("capture value wrong");

  a_sleep_stop: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    sleep_i && !irq_cfg_i.sync_bypass && !wr_any && !special_hit |=> $stable(counter_o))
    else $error("counter moved during sleep");

  a_irq_gating: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    rollover_irq_o |-> rollover_flag_o && irq_cfg_i.global_irq_enable && irq_cfg_i.timer_run)
    else $error("rollover request without enables");
endmodule
`default_nettype wire

// ==== verilog/timer_gate_pkg.sv ====
/*
  Shared constants and carrier types for the gate-controlled 16-bit timer.
  Assumes one system clock; all control bits arrive as plain ports.
*/
`default_nettype none
package timer_gate_pkg;
  localparam int          CNT_W          = 16;
  localparam logic [15:0] CNT_MAX        = 16'hffff;
  localparam logic [15:0] CNT_ZERO       = 16'h0000;
  localparam logic [1:0]  GSRC_WATCHDOG  = 2'h3;
  localparam logic [15:0] ISR_VECTOR     = 16'h0004;
  localparam logic [1:0]  SYNC_ZERO      = 2'h0;

  typedef enum logic [1:0] {
    CCP_OFF,
    CCP_CAPTURE,
    CCP_COMPARE,
    CCP_SPECIAL
  } ccp_mode_t;

  typedef struct packed {
    logic       gate_enable;
    logic       gate_polarity;
    logic       gate_toggle_enable;
    logic       gate_single_pulse_enable;
    logic       gate_arm_set;
    logic [1:0] gate_source_select;
  } gate_cfg_t;

  typedef struct packed {
    logic timer_run;
    logic sync_bypass;
    logic rollover_irq_enable;
    logic gate_event_irq_enable;
    logic peripheral_irq_enable;
    logic global_irq_enable;
    logic watchdog_enable;
  } irq_cfg_t;

  typedef struct packed {
    logic       wr_low;
    logic       wr_high;
    logic [7:0] wdata;
  } cnt_wr_t;

  typedef struct packed {
    logic wd_osc_run;
    logic wd_reset_allow;
    logic wd_wake_allow;
  } wdog_ctl_t;
endpackage
`default_nettype wire
